/* rtl/csdec_pkg.sv */
// Purpose: Shared constants and types for the chip select and wait state decoder.
// Assumes: Four external selects, 24-bit memory address, 16-bit I/O address, 8-bit registers.
// Notes: Register address is {select[1:0], offset[1:0]} on the plain register port.
package csdec_pkg;

    // Geometry
    localparam int unsigned NUM_SEL = 4;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned REG_AW = 4;

    // Register offsets inside one select's group
    localparam logic [1:0] OFS_CTL = 2'h0;
    localparam logic [1:0] OFS_LBR = 2'h1;
    localparam logic [1:0] OFS_UBR = 2'h2;
    localparam logic [1:0] OFS_STAT = 2'h3;

    // Control register fields
    localparam int unsigned CTL_WAIT_LSB = 5;
    localparam int unsigned CTL_WAIT_MSB = 7;
    localparam int unsigned CTL_IO_BIT = 4;
    localparam int unsigned CTL_EN_BIT = 3;

    // Status register fields
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_STALL_BIT = 1;
    localparam int unsigned STAT_WAITPIN_BIT = 2;

    // Reset values
    localparam logic [7:0] CTL_RST_SEL0 = 8'hE8;
    localparam logic [7:0] CTL_RST_OTHER = 8'h00;
    localparam logic [7:0] LBR_RST = 8'h00;
    localparam logic [7:0] UBR_RST_SEL0 = 8'hFF;
    localparam logic [7:0] UBR_RST_OTHER = 8'h00;

    // On-chip peripheral window: I/O high byte of zero
    localparam logic [7:0] IO_PERIPH_HI = 8'h00;

    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_END = 3'b100
    } csdec_state_t;

endpackage : csdec_pkg

/* rtl/csdec_top.sv */
// Purpose: Decodes CPU or bus-master accesses into four active-low chip selects with wait states.
// Assumes: CPU holds its request level until done_o, then drops it; wait_n_i and ext_* are raw pins.
// Notes: Register address is {select, offset}; the rules carried out below follow.
// Summary of operation
// RULE1 - Each select serves memory when its space bit is 0, I/O when 1.
// RULE2 - After reset all four selects are set for memory space.
// RULE3 - A select never asserts unless its enable bit is 1.
// RULE4 - Memory select matches when lower bound <= address top byte <= upper bound.
// RULE5 - Internal RAM and flash hits suppress every external memory select.
// RULE6 - Among several matching selects only the lowest numbered one asserts.
// RULE7 - Memory selects assert only on memory access, with memory request and strobe low.
// RULE8 - Equal bounds give exactly one 64 KB page.
// RULE9 - Select 0 resets to bounds 00h..FFh, others to 00h..00h.
// RULE10 - I/O selects assert only on I/O access, with I/O request and strobe low.
// RULE11 - I/O select matches address bits 15:8 against its lower bound only.
// RULE12 - I/O addresses 0000h..00FFh never raise an external select.
// RULE13 - Each select stalls the CPU for its 3-bit wait count of cycles; the code stalls for the count plus one cycle.
// RULE14 - Low wait input stalls; resume on first edge after it returns high; the code resumes on the third edge, after the two-flop synchroniser.
// RULE15 - Devices using the wait input need at least one wait state, seven preferred.
// RULE16 - After programmed waits, extra wait cycles while wait input stays low.
// RULE17 - During bus grant the externally driven address is decoded as usual.
// RULE18 - All selects and strobes stay high when nothing matches.
module csdec_top
    import csdec_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // CPU access side
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_mem_i,
    input wire logic cpu_io_i,
    input wire logic cpu_write_i,
    input wire logic ram_hit_i,
    input wire logic flash_hit_i,
    output logic cpu_stall_o,
    output logic done_o,
    // External bus master pins
    input wire logic bus_grant_n_i,
    input wire logic [ADDR_W-1:0] ext_addr_i,
    input wire logic ext_mem_i,
    input wire logic ext_io_i,
    input wire logic ext_write_i,
    // External wait pin
    input wire logic wait_n_i,
    // External bus strobes
    output logic select_out_0_n_o,
    output logic select_out_1_n_o,
    output logic select_out_2_n_o,
    output logic select_out_3_n_o,
    output logic memory_request_n_o,
    output logic io_request_n_o,
    output logic read_n_o,
    output logic write_n_o
);

    // Configuration storage
    logic [7:0] lbr_q [NUM_SEL];
    logic [7:0] ubr_q [NUM_SEL];
    logic [2:0] wcnt_cfg_q [NUM_SEL];
    logic io_q [NUM_SEL];
    logic en_q [NUM_SEL];

    // Synchronisers for pins
    logic wait_s1_q, wait_s2_q;
    logic [ADDR_W+2:0] ext_s1_q, ext_s2_q;

    // Decode inputs
    logic [ADDR_W-1:0] dec_addr;
    logic dec_mem, dec_io, dec_write;
    logic mem_kind, io_kind;
    logic [NUM_SEL-1:0] mem_hit, io_hit, match_vec;
    logic any_match;
    logic [1:0] pick_d;

    // Sequencer
    csdec_state_t state_q, state_d;
    logic [1:0] sel_q;
    logic [2:0] cnt_q;
    logic [2:0] wt_q;
    logic [NUM_SEL-1:0] sel_n_q;
    logic mem_req_n_q, ioreq_n_q, rd_n_q, wr_n_q;
    logic done_q;
    logic [7:0] rdata_q;
    logic start, finish;

    // Two-flop capture of the wait pin and the external master's bus; first stage read by second only
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_s1_q <= 1'b1;
            wait_s2_q <= 1'b1;
            ext_s1_q <= '0;
            ext_s2_q <= '0;
        end else if (ce_i) begin
            wait_s1_q <= wait_n_i;
            wait_s2_q <= wait_s1_q;
            ext_s1_q <= {ext_write_i, ext_io_i, ext_mem_i, ext_addr_i};
            ext_s2_q <= ext_s1_q;
        end
    end

    // Source select: granted bus means the outside master's address drives decode [RULE17]
    assign dec_addr = bus_grant_n_i ? cpu_addr_i : ext_s2_q[ADDR_W-1:0];
    assign dec_mem = bus_grant_n_i ? cpu_mem_i : ext_s2_q[ADDR_W];
    assign dec_io = bus_grant_n_i ? cpu_io_i : ext_s2_q[ADDR_W+1];
    assign dec_write = bus_grant_n_i ? cpu_write_i : ext_s2_q[ADDR_W+2];

    // Access kind; internal memories and the peripheral window win over external selects
    assign mem_kind = dec_mem & ~dec_io & ~ram_hit_i & ~flash_hit_i; // [RULE5] [RULE7]
    assign io_kind = dec_io & ~dec_mem & (dec_addr[15:8] != IO_PERIPH_HI); // [RULE10] [RULE12]

    // Per-select range and byte compare
    for (genvar g = 0; g < NUM_SEL; g++) begin : g_match
        // Inclusive bounds, so equal bounds leave exactly one 64 KB page [RULE4] [RULE8]
        assign mem_hit[g] = en_q[g] & ~io_q[g] // [RULE1] [RULE3]
            & (dec_addr[23:16] >= lbr_q[g]) & (dec_addr[23:16] <= ubr_q[g]);
        // Only the I/O high byte counts, against the lower bound; top byte and upper bound play no part [RULE11]
        assign io_hit[g] = en_q[g] & io_q[g] & (dec_addr[15:8] == lbr_q[g]); // [RULE1] [RULE3]
    end

    assign match_vec = mem_kind ? mem_hit : (io_kind ? io_hit : '0);
    assign any_match = |match_vec;

    // Fixed priority: scan downward so the lowest index is left standing [RULE6]
    always_comb begin
        pick_d = 2'h0;
        for (int i = NUM_SEL - 1; i >= 0; i--) begin
            if (match_vec[i]) begin
                pick_d = i[1:0];
            end
        end
    end

    // Configuration writes; select 0 alone covers all memory after reset [RULE2] [RULE9]
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                lbr_q[i] <= LBR_RST;
                ubr_q[i] <= (i == 0) ? UBR_RST_SEL0 : UBR_RST_OTHER;
                wcnt_cfg_q[i] <= (i == 0) ? CTL_RST_SEL0[CTL_WAIT_MSB:CTL_WAIT_LSB]
                    : CTL_RST_OTHER[CTL_WAIT_MSB:CTL_WAIT_LSB];
                io_q[i] <= (i == 0) ? CTL_RST_SEL0[CTL_IO_BIT] : CTL_RST_OTHER[CTL_IO_BIT];
                en_q[i] <= (i == 0) ? CTL_RST_SEL0[CTL_EN_BIT] : CTL_RST_OTHER[CTL_EN_BIT];
            end
        end else if (ce_i && reg_wr_i) begin
            unique case (reg_addr_i[1:0])
                OFS_CTL: begin
                    wcnt_cfg_q[reg_addr_i[3:2]] <= reg_wdata_i[CTL_WAIT_MSB:CTL_WAIT_LSB];
                    io_q[reg_addr_i[3:2]] <= reg_wdata_i[CTL_IO_BIT];
                    en_q[reg_addr_i[3:2]] <= reg_wdata_i[CTL_EN_BIT];
                end
                OFS_LBR: lbr_q[reg_addr_i[3:2]] <= reg_wdata_i;
                OFS_UBR: ubr_q[reg_addr_i[3:2]] <= reg_wdata_i;
                OFS_STAT: ; // Status is read-only, writes ignored
            endcase
        end
    end

    // Read port: data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            rdata_q <= 8'h00;
            if (reg_rd_i) begin
                unique case (reg_addr_i[1:0])
                    OFS_CTL: begin
                        rdata_q[CTL_WAIT_MSB:CTL_WAIT_LSB] <= wcnt_cfg_q[reg_addr_i[3:2]];
                        rdata_q[CTL_IO_BIT] <= io_q[reg_addr_i[3:2]];
                        rdata_q[CTL_EN_BIT] <= en_q[reg_addr_i[3:2]];
                    end
                    OFS_LBR: rdata_q <= lbr_q[reg_addr_i[3:2]];
                    OFS_UBR: rdata_q <= ubr_q[reg_addr_i[3:2]];
                    OFS_STAT: begin
                        rdata_q[STAT_ACTIVE_BIT] <= ~sel_n_q[reg_addr_i[3:2]];
                        rdata_q[STAT_STALL_BIT] <= cpu_stall_o;
                        rdata_q[STAT_WAITPIN_BIT] <= ~wait_s2_q;
                    end
                endcase
            end
        end
    end
    assign reg_rdata_o = rdata_q;

    // Access begins only from idle on a matching request; wait ends on count zero and pin high
    assign start = (state_q == ST_IDLE) && any_match;
    assign finish = (state_q == ST_ACCESS) && (cnt_q == 3'h0) && wait_s2_q; // [RULE14] [RULE16]

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (any_match) state_d = ST_ACCESS;
            ST_ACCESS: if (finish) state_d = ST_END;
            // Hold off until the request drops so one request is served once
            ST_END: if (!(dec_mem || dec_io)) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // Wait counter loaded from the chosen select's field on entry [RULE13]
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 3'h0;
            wt_q <= 3'h0;
            sel_q <= 2'h0;
        end else if (ce_i) begin
            if (start) begin
                cnt_q <= wcnt_cfg_q[pick_d];
                wt_q <= wcnt_cfg_q[pick_d];
                sel_q <= pick_d;
            end else if (state_q == ST_ACCESS && cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    // Strobes: one select plus the matching request and direction strobe, high otherwise [RULE18]
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_n_q <= '1;
            mem_req_n_q <= 1'b1;
            ioreq_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (ce_i) begin
            if (start) begin
                sel_n_q <= ~(NUM_SEL'(1) << pick_d); // [RULE6]
                mem_req_n_q <= ~mem_kind; // [RULE7]
                ioreq_n_q <= ~io_kind; // [RULE10]
                rd_n_q <= dec_write;
                wr_n_q <= ~dec_write;
            end else if (finish) begin
                sel_n_q <= '1;
                mem_req_n_q <= 1'b1;
                ioreq_n_q <= 1'b1;
                rd_n_q <= 1'b1;
                wr_n_q <= 1'b1;
            end
        end
    end

    // Completion pulse coincides with strobes returning high
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= finish;
        end
    end

    // Stall is combinational so the CPU freezes in the same cycle the select is low
    assign cpu_stall_o = (state_q == ST_ACCESS); // [RULE13] [RULE14]
    assign done_o = done_q;
    assign select_out_0_n_o = sel_n_q[0];
    assign select_out_1_n_o = sel_n_q[1];
    assign select_out_2_n_o = sel_n_q[2];
    assign select_out_3_n_o = sel_n_q[3];
    assign memory_request_n_o = mem_req_n_q;
    assign io_request_n_o = ioreq_n_q;
    assign read_n_o = rd_n_q;
    assign write_n_o = wr_n_q;

    // Helper: cycles spent in the access state, saturating
    logic [3:0] hlp_cnt_q;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hlp_cnt_q <= 4'h0;
        end else if (ce_i) begin
            if (start) begin
                hlp_cnt_q <= 4'h0;
            end else if (state_q == ST_ACCESS && hlp_cnt_q != 4'hF) begin
                hlp_cnt_q <= hlp_cnt_q + 4'h1;
            end
        end
    end

    // Checks; a frozen clock enable aborts attempts in flight
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i || !ce_i);

    sequence s_entry;
        start;
    endsequence

    sequence s_leave;
        (state_q == ST_ACCESS) ##1 (state_q == ST_END);
    endsequence

    a_space_exclusive: assert property (!(mem_req_n_q == 1'b0 && ioreq_n_q == 1'b0)) // [RULE1]
        else $error("memory and I/O request low together");

    a_enable_needed: assert property (s_entry |=> ($past(en_q[pick_d]) && sel_n_q[sel_q] == 1'b0)) // [RULE3]
        else $error("select asserted without enable");

    a_mem_bounds: assert property (s_entry and mem_kind |=>
        ($past(dec_addr[23:16]) >= $past(lbr_q[pick_d]) && $past(dec_addr[23:16]) <= $past(ubr_q[pick_d])
        && !memory_request_n_o)) // [RULE4]
        else $error("memory select outside its bounds");

    a_internal_wins: assert property ((state_q == ST_IDLE) && (ram_hit_i || flash_hit_i) && dec_mem && !dec_io
        |=> memory_request_n_o && (&sel_n_q)) // [RULE5]
        else $error("external select during internal memory hit");

    a_lowest_wins: assert property (s_entry |=>
        (($past(match_vec) & ((NUM_SEL'(1) << sel_q) - NUM_SEL'(1))) == '0)) // [RULE6]
        else $error("higher numbered select beat a lower one");

    a_io_periph: assert property (s_entry and io_kind |=> // [RULE12]
        ($past(dec_addr[15:8]) != IO_PERIPH_HI && !io_request_n_o))
        else $error("I/O select in on-chip peripheral window");

    a_io_strobes: assert property (s_entry and io_kind |=> // [RULE10]
        !io_request_n_o && memory_request_n_o && (read_n_o != write_n_o))
        else $error("I/O access without its request strobe");

    a_io_match: assert property (s_entry and io_kind |=> // [RULE11]
        $past(dec_addr[15:8]) == $past(lbr_q[pick_d]))
        else $error("I/O select on a high byte it does not own");

    a_wait_count: assert property (s_leave |-> ($past(hlp_cnt_q) >= {1'b0, wt_q})) // [RULE13]
        else $error("access left before programmed wait states");

    a_wait_extend: assert property ((state_q == ST_ACCESS) && (cnt_q == 3'h0) && !wait_s2_q
        |=> (state_q == ST_ACCESS) && cpu_stall_o) // [RULE16]
        else $error("wait input low but access ended");

    a_wait_release: assert property ((state_q == ST_ACCESS) && (cnt_q == 3'h0) && wait_s2_q
        |=> !cpu_stall_o && done_o && (&sel_n_q) ##1 !done_o) // [RULE14]
        else $error("no resume after wait input high");

    a_idle_quiet: assert property ((state_q == ST_IDLE) |-> // [RULE18]
        (&sel_n_q) && mem_req_n_q && ioreq_n_q && rd_n_q && wr_n_q)
        else $error("strobe low while idle");

endmodule : csdec_top

/* tb/csdec_periph.sv */
// Purpose: Behavioural external peripheral that stretches accesses with the wait pin.
// Assumes: Any low select starts one access; stretch_i gives how many cycles to pull wait low.
// Notes: Wait is released between accesses, so the line rests at its pulled-up high level.
module csdec_periph (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Bus side
    input wire logic [3:0] sel_n_i,
    input wire logic [3:0] stretch_i,
    output logic wait_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_q;
    logic busy_q;

    // Start one stretch at the first cycle a select is seen low, never re-arm within it
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            busy_q <= (sel_n_i != 4'hF);
            if (!busy_q && sel_n_i != 4'hF) begin
                cnt_q <= stretch_i;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // Low while stretching, released high otherwise
    assign wait_n_o = (cnt_q == 4'h0);
endmodule : csdec_periph

/* tb/csdec_top_test.sv */
// Purpose: Self-checking bench for the chip select and wait state decoder.
// Assumes: Shadow copies of the select registers predict every decode and stall length.
// Notes: Corner cases first, then random configs and accesses from a fixed xorshift seed.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module csdec_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [23:0] cpu_addr_i = 24'h0;
    logic [23:0] ext_addr_i = 24'h0;
    logic cpu_mem_i = 1'b0, cpu_io_i = 1'b0, cpu_write_i = 1'b0, ram_hit_i = 1'b0, flash_hit_i = 1'b0;
    logic ext_mem_i = 1'b0, ext_io_i = 1'b0, ext_write_i = 1'b0, bus_grant_n_i = 1'b1;
    logic [3:0] stretch = 4'h0;
    logic wait_n;
    logic [7:0] reg_rdata_o;
    logic cpu_stall_o, done_o, mem_req_n, ioreq_n, rd_n, wr_n;
    logic [3:0] sel_n;
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h414E;
    logic [7:0] ctl [4] = '{csdec_pkg::CTL_RST_SEL0, 8'h00, 8'h00, 8'h00};
    logic [7:0] lbr [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ubr [4] = '{8'hFF, 8'h00, 8'h00, 8'h00};
    logic [23:0] pg [4] = '{24'h5A0000, 24'h5AFFFF, 24'h5B0000, 24'h59FFFF};

    csdec_top i_csdec_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .cpu_addr_i(cpu_addr_i), .cpu_mem_i(cpu_mem_i), .cpu_io_i(cpu_io_i), .cpu_write_i(cpu_write_i),
        .ram_hit_i(ram_hit_i), .flash_hit_i(flash_hit_i), .cpu_stall_o(cpu_stall_o), .done_o(done_o),
        .bus_grant_n_i(bus_grant_n_i), .ext_addr_i(ext_addr_i), .ext_mem_i(ext_mem_i), .ext_io_i(ext_io_i),
        .ext_write_i(ext_write_i), .wait_n_i(wait_n), .select_out_0_n_o(sel_n[0]),
        .select_out_1_n_o(sel_n[1]), .select_out_2_n_o(sel_n[2]), .select_out_3_n_o(sel_n[3]),
        .memory_request_n_o(mem_req_n), .io_request_n_o(ioreq_n), .read_n_o(rd_n), .write_n_o(wr_n));

    csdec_periph i_csdec_periph (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sel_n_i(sel_n),
        .stretch_i(stretch), .wait_n_o(wait_n));

    // 100 MHz system clock
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    // Repeatable pseudo random source
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Lowest numbered enabled select of the right space wins; 4 means none
    function automatic int exp_sel(bit m, bit io, logic [23:0] a, bit ram, bit fl);
        if (m == io || (m && (ram || fl)) || (io && a[15:8] == 8'h00)) begin
            return 4;
        end
        for (int i = 0; i < 4; i++) begin
            if (ctl[i][3] && ctl[i][4] == io && (m ? (lbr[i] <= a[23:16] && a[23:16] <= ubr[i])
                : (a[15:8] == lbr[i]))) begin
                return i;
            end
        end
        return 4;
    endfunction : exp_sel

    // Expected read back; the status group reads idle
    function automatic logic [7:0] exp_reg(logic [3:0] a);
        case (a[1:0])
            2'h0: return ctl[a[3:2]];
            2'h1: return lbr[a[3:2]];
            2'h2: return ubr[a[3:2]];
            default: return 8'h00;
        endcase
    endfunction : exp_reg

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        // Low control bits are not stored and status writes are dropped
        case (a[1:0])
            2'h0: ctl[a[3:2]] = d & 8'hF8;
            2'h1: lbr[a[3:2]] = d;
            2'h2: ubr[a[3:2]] = d;
            default: ;
        endcase
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, exp_reg(a))
    endtask : reg_read

    // One access by the CPU, or by the external master when g is set
    task automatic access(input bit m, input bit io, input logic [23:0] a, input bit wr, input bit ram,
                          input bit fl, input bit g, input logic [3:0] s);
        int e;
        int w;
        int x;
        int n;
        logic [7:0] ex;
        e = exp_sel(m, io, a, ram, fl);
        w = (e < 4) ? int'(ctl[e][7:5]) : 0;
        if (w != 7) s = 4'h0;
        x = (e == 4) ? 0 : ((s != 0 && w + 1 >= 4 && w + 1 <= s + 3) ? s + 4 : w + 1);
        ex = (e < 4) ? {~(4'h1 << e), ~m, ~io, wr, ~wr} : 8'hFF;
        n = 0;
        @(posedge mclk_i);
        bus_grant_n_i <= ~g;
        stretch <= s;
        ram_hit_i <= ram;
        flash_hit_i <= fl;
        if (g) begin
            {ext_mem_i, ext_io_i, ext_write_i, ext_addr_i, cpu_addr_i} <= {m, io, wr, a, ~a};
        end else begin
            {cpu_mem_i, cpu_io_i, cpu_write_i, cpu_addr_i} <= {m, io, wr, a};
        end
        for (int k = 0; k < 40 && done_o !== 1'b1; k++) begin
            @(posedge mclk_i);
            #1;
            if ({sel_n, mem_req_n, ioreq_n, rd_n, wr_n} !== 8'hFF && done_o !== 1'b1) begin
                n++;
                `CHK({sel_n, mem_req_n, ioreq_n, rd_n, wr_n, cpu_stall_o | g}, {ex, 1'b1})
            end
        end
        `CHK(done_o, 1'(e < 4))
        `CHK(n, x)
        @(posedge mclk_i);
        {cpu_mem_i, cpu_io_i, ext_mem_i, ext_io_i, ram_hit_i, flash_hit_i} <= 6'h00;
        #1 `CHK({done_o, sel_n, mem_req_n, ioreq_n, rd_n, wr_n}, 9'h0FF)
        repeat (3) @(posedge mclk_i);
        bus_grant_n_i <= 1'b1;
    endtask : access

    task wrap_up();
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // Cut a hang short well beyond the expected run length
    initial begin
        repeat (30000) @(posedge mclk_i);
        num_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        int i;
        int j;
        logic [31:0] r;
        logic [23:0] a;
        repeat (10) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (int k = 0; k < 16; k++) reg_read(k[3:0]);
        reg_write(4'h3, 8'hFF);
        reg_read(4'h3);
        // Frozen clock enable: a write offered in that cycle must not land
        @(posedge mclk_i);
        {ce_i, reg_wr_i, reg_addr_i, reg_wdata_i} <= {2'b01, 4'h1, 8'h77};
        @(posedge mclk_i);
        {ce_i, reg_wr_i} <= 2'b10;
        reg_read(4'h1);
        access(1'b1, 1'b0, 24'hC3A512, 1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
        access(1'b1, 1'b0, 24'h001234, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
        access(1'b1, 1'b0, 24'h001234, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
        reg_write(4'h0, 8'h00);
        reg_write(4'h5, 8'h5A);
        reg_write(4'h6, 8'h5A);
        reg_write(4'h4, 8'h08);
        for (int k = 0; k < 4; k++) access(1'b1, 1'b0, pg[k], 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        reg_write(4'h8, 8'h38);
        reg_write(4'h9, 8'h45);
        reg_write(4'hC, 8'h18);
        access(1'b0, 1'b1, 24'h124512, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
        access(1'b0, 1'b1, 24'h0000AB, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        // Random configs, biased so that bounds and the peripheral window are hit often
        for (int it = 0; it < 70; it++) begin
            i = rnd() % 4;
            r = rnd();
            reg_write({i[1:0], 2'h0}, r[7:0]);
            reg_write({i[1:0], 2'h1}, r[15:8]);
            reg_write({i[1:0], 2'h2}, r[16] ? r[15:8] : r[31:24]);
            reg_read({r[19:18], r[21:20]});
            j = rnd() % 4;
            r = rnd();
            a = {r[2] ? lbr[j] : (r[3] ? ubr[j] : r[31:24]), r[4] ? (r[5] ? 8'h00 : lbr[j]) : r[23:16], r[15:8]};
            access(r[6], ~r[6] | (r[30:28] == 3'h0), a, r[7], r[26:24] == 3'h0, r[29:27] == 3'h0,
                   r[1:0] == 2'h0, r[11:8]);
        end
        wrap_up();
    end
endmodule : csdec_top_test
